// ==== hw/fcbd_diag.sv ====
// fault code blink diagnostics: mode select, lamp, blink encoder, clearing
// Functional notes
// R1: three modes chosen by terminal grounding pattern
// R2: rider mode lamp on for any fault
// R3: serious fault inhibits injection, ignition, starter
// R4: live mode blinks present fault codes
// R5: stored mode blinks retained fault codes
// R6: ground over 2 s enters live mode
// R7: over five toggles then 2 s: stored
// R8: no live-to-stored switch without ignition off
// R9: technician holds clutch over 5 s
// R10: clutch then toggles and hold erase memory
// R11: tens digit long blinks, units short blinks
// R12: store all faults, show ascending
// R13: repeat list until terminal released
// R14: no fault means no code, lamp off
// R15: excluded parts never recorded or lit
// R16: stored codes persist until clear sequence
// R17: sensor codes 11 12 13 14 21
// R18: tip-over 31, subthrottle 32, oxygen 33
// R19: actuator codes 51 52 56 62 64 67 94
// R20: speed fault shown as 24 then 25
// R21: blink timings are cycle parameters
// R22: inputs debounced before timing and counting
`timescale 1ns/1ns
`default_nettype none
module fcbd_diag #(
  parameter int LONG_CYC = 25000000,
  parameter int SHORT_CYC = 10000000,
  parameter int GAP_CYC = 15000000,
  parameter int DIGIT_GAP_CYC = 50000000,
  parameter int CODE_GAP_CYC = 100000000,
  parameter int SEL_CYC = fcbd_pkg::SEL_MS * fcbd_pkg::MS_CYC,
  parameter int CLUTCH_CYC = fcbd_pkg::CLUTCH_MS * fcbd_pkg::MS_CYC,
  parameter int DEB_CYC = fcbd_pkg::DEB_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ignitionOn,
  input wire logic diagGrounded,
  input wire logic clutchPulled,
  input wire fcbd_pkg::fcbd_faults_t faultIn,
  input wire logic o2Fitted,
  input wire logic seriousFault,
  output logic faultLamp,
  output fcbd_pkg::fcbd_inhibit_t inhibit,
  output fcbd_pkg::fcbd_mode_t mode,
  output fcbd_pkg::fcbd_faults_t storedFaults
);
  function automatic fcbd_pkg::fcbd_code_t codeOf(input logic [4:0] i);
    fcbd_pkg::fcbd_code_t c;
    c = '0;
    case (i)
      5'h00: c = '{4'h1, 4'h1}; // [R17]
      5'h01: c = '{4'h1, 4'h2};
      5'h02: c = '{4'h1, 4'h3};
      5'h03: c = '{4'h1, 4'h4};
      5'h04: c = '{4'h2, 4'h1};
      5'h05: c = '{4'h2, 4'h4}; // [R20]
      5'h06: c = '{4'h2, 4'h5};
      5'h07: c = '{4'h3, 4'h1}; // [R18]
      5'h08: c = '{4'h3, 4'h2};
      5'h09: c = '{4'h3, 4'h3};
      5'h0a: c = '{4'h5, 4'h1}; // [R19]
      5'h0b: c = '{4'h5, 4'h2};
      5'h0c: c = '{4'h5, 4'h6};
      5'h0d: c = '{4'h6, 4'h2};
      5'h0e: c = '{4'h6, 4'h4};
      5'h0f: c = '{4'h6, 4'h7};
      5'h10: c = '{4'h9, 4'h4};
      default: c = '0;
    endcase
    return c;
  endfunction

  // lowest set index at or after start, wrapping; found=0 if none
  function automatic logic [5:0] nextSet(input fcbd_pkg::fcbd_faults_t f, input logic [4:0] start);
    logic [5:0] r;
    logic [5:0] k;
    r = '0;
    for (int j = fcbd_pkg::NCODE - 1; j >= 0; j--) begin
      k = 6'(start) + 6'(j);
      if (k >= 6'(fcbd_pkg::NCODE)) k = k - 6'(fcbd_pkg::NCODE);
      if (f[k[4:0]]) r = {1'b1, k[4:0]};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////
  // input conditioning
  logic [1:0] gSync, cSync;
  logic gDeb, cDeb;
  logic [19:0] gCnt, cCnt;
  logic [1:0] next_gSync, next_cSync;
  logic next_gDeb, next_cDeb;
  logic [19:0] next_gCnt, next_cCnt;
  always_comb begin
    next_gSync = {gSync[0], diagGrounded};
    next_cSync = {cSync[0], clutchPulled};
    next_gDeb = gDeb;
    next_cDeb = cDeb;
    next_gCnt = '0;
    next_cCnt = '0;
    if (gSync[1] != gDeb) begin // [R22]
      next_gCnt = gCnt + 20'h00001;
      if (gCnt >= 20'(DEB_CYC - 1)) next_gDeb = gSync[1];
    end
    if (cSync[1] != cDeb) begin // [R22]
      next_cCnt = cCnt + 20'h00001;
      if (cCnt >= 20'(DEB_CYC - 1)) next_cDeb = cSync[1];
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gSync <= '0;
      cSync <= '0;
      gDeb <= 1'b0;
      cDeb <= 1'b0;
      gCnt <= '0;
      cCnt <= '0;
    end else begin
      gSync <= next_gSync;
      cSync <= next_cSync;
      gDeb <= next_gDeb;
      cDeb <= next_cDeb;
      gCnt <= next_gCnt;
      cCnt <= next_cCnt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // fault capture and memory
  fcbd_pkg::fcbd_faults_t live;
  logic erase;
  always_comb begin
    live = faultIn; // [R15] excluded parts have no input bit
    if (!o2Fitted) live[fcbd_pkg::F_O2INACT] = 1'b0; // [R18]
    live[fcbd_pkg::F_SPEED2] = faultIn[fcbd_pkg::F_SPEED]; // [R20]
  end
  fcbd_store u_store ( // [R16]
    .sys_clk(sys_clk),
    .nrst(nrst),
    .setBits(live), // [R12]
    .erase(erase),
    .stored(storedFaults)
  );

  ////////////////////////////////////////////////////////////////
  // mode selection
  typedef enum logic [2:0] {S_IDLE, S_FIRST, S_HOLD, S_DONE, S_CLUTCH, S_CTOG} fcbd_sel_t;
  fcbd_sel_t sel, next_sel;
  fcbd_pkg::fcbd_mode_t next_mode;
  logic [31:0] tCnt, next_tCnt;
  logic [3:0] togs, next_togs;
  logic gPrev, next_gPrev, livePast, next_livePast;
  logic gRise;
  assign gRise = gDeb && !gPrev;
  always_comb begin
    next_sel = sel;
    next_mode = mode;
    next_tCnt = tCnt + 32'h1;
    next_togs = togs;
    next_gPrev = gDeb;
    next_livePast = livePast;
    erase = 1'b0;
    if (!ignitionOn) begin // [R8]
      next_sel = S_IDLE;
      next_mode = fcbd_pkg::FCBD_RIDER;
      next_livePast = 1'b0;
      next_tCnt = '0;
      next_togs = '0;
    end else begin
      case (sel)
        S_IDLE: begin
          next_tCnt = '0;
          next_togs = '0;
          if (gRise) next_sel = S_FIRST;
        end
        S_FIRST: begin // [R1]
          if (gRise) next_togs = togs + 4'h1; // [R7]
          if (tCnt >= 32'(SEL_CYC)) begin
            if (togs > fcbd_pkg::TOGGLE_MIN && !livePast) begin
              next_sel = S_HOLD;
              next_tCnt = '0;
            end else if (gDeb && togs == 4'h0) begin
              next_sel = S_DONE;
              next_mode = fcbd_pkg::FCBD_LIVE; // [R6]
              next_livePast = 1'b1;
            end else begin
              next_sel = S_IDLE;
            end
          end
        end
        S_HOLD: begin
          if (!gDeb) next_sel = S_IDLE;
          else if (tCnt >= 32'(SEL_CYC)) begin
            next_sel = S_DONE;
            next_mode = fcbd_pkg::FCBD_STORED; // [R7]
          end
        end
        S_DONE: begin
          next_tCnt = '0;
          if (!gDeb) begin // [R13]
            next_sel = S_IDLE;
            next_mode = fcbd_pkg::FCBD_RIDER;
          end else if (mode == fcbd_pkg::FCBD_STORED && cDeb) next_sel = S_CLUTCH;
        end
        S_CLUTCH: begin // [R9]
          if (!cDeb) begin
            next_sel = tCnt >= 32'(CLUTCH_CYC) ? S_CTOG : S_DONE;
            next_tCnt = '0;
            next_togs = '0;
          end
        end
        S_CTOG: begin // [R10]
          if (gRise) next_togs = togs + 4'h1;
          if (tCnt >= 32'(2 * SEL_CYC)) begin
            next_sel = S_DONE;
          end else if (tCnt >= 32'(SEL_CYC) && togs > fcbd_pkg::TOGGLE_MIN && gDeb &&
                       tCnt >= 32'(SEL_CYC) + 32'(SEL_CYC) - 32'h1) begin
            erase = 1'b1;
            next_sel = S_DONE;
          end
        end
        default: next_sel = S_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sel <= S_IDLE;
      mode <= fcbd_pkg::FCBD_RIDER;
      tCnt <= '0;
      togs <= '0;
      gPrev <= 1'b0;
      livePast <= 1'b0;
    end else begin
      sel <= next_sel;
      mode <= next_mode;
      tCnt <= next_tCnt;
      togs <= next_togs;
      gPrev <= next_gPrev;
      livePast <= next_livePast;
    end
  end

  ////////////////////////////////////////////////////////////////
  // blink encoder
  typedef enum logic [2:0] {B_IDLE, B_ON, B_OFF, B_DGAP, B_CGAP} fcbd_blink_t;
  fcbd_blink_t bst, next_bst;
  logic [4:0] idx, next_idx;
  logic [3:0] left, next_left;
  logic units, next_units;
  logic [31:0] bCnt, next_bCnt;
  logic next_faultLamp;
  fcbd_pkg::fcbd_inhibit_t next_inhibit;
  fcbd_pkg::fcbd_faults_t src;
  logic [5:0] pick;
  fcbd_pkg::fcbd_code_t pickCode, idxCode;
  logic showing;
  assign showing = mode != fcbd_pkg::FCBD_RIDER;
  assign src = mode == fcbd_pkg::FCBD_STORED ? storedFaults : live; // [R4] [R5]
  assign pick = nextSet(src, idx);
  assign pickCode = codeOf(pick[4:0]);
  assign idxCode = codeOf(idx);
  always_comb begin
    next_bst = bst;
    next_idx = idx;
    next_left = left;
    next_units = units;
    next_bCnt = bCnt + 32'h1;
    next_inhibit = '{seriousFault, seriousFault, seriousFault}; // [R3]
    next_faultLamp = |live; // [R2] [R14]
    if (!showing) begin
      next_bst = B_IDLE;
      next_idx = '0;
    end else begin
      next_faultLamp = bst == B_ON;
      case (bst)
        B_IDLE: begin
          next_bCnt = '0;
          if (pick[5]) begin // [R14]
            next_idx = pick[4:0];
            next_left = pickCode.tens; // [R11]
            next_units = 1'b0;
            next_bst = B_ON;
          end
        end
        B_ON: begin
          if (bCnt >= 32'(units ? SHORT_CYC - 1 : LONG_CYC - 1)) begin // [R21]
            next_bCnt = '0;
            next_left = left - 4'h1;
            next_bst = left == 4'h1 ? (units ? B_CGAP : B_DGAP) : B_OFF;
          end
        end
        B_OFF: if (bCnt >= 32'(GAP_CYC - 1)) begin
          next_bCnt = '0;
          next_bst = B_ON;
        end
        B_DGAP: if (bCnt >= 32'(DIGIT_GAP_CYC - 1)) begin
          next_bCnt = '0;
          next_units = 1'b1;
          next_left = idxCode.units; // [R11]
          next_bst = next_left == 4'h0 ? B_CGAP : B_ON;
        end
        B_CGAP: if (bCnt >= 32'(CODE_GAP_CYC - 1)) begin // [R12] [R13]
          next_idx = idx == 5'(fcbd_pkg::NCODE - 1) ? 5'h00 : idx + 5'h01;
          next_bst = B_IDLE;
        end
        default: next_bst = B_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bst <= B_IDLE;
      idx <= '0;
      left <= '0;
      units <= 1'b0;
      bCnt <= '0;
      faultLamp <= 1'b0;
      inhibit <= '0;
    end else begin
      bst <= next_bst;
      idx <= next_idx;
      left <= next_left;
      units <= next_units;
      bCnt <= next_bCnt;
      faultLamp <= next_faultLamp;
      inhibit <= next_inhibit;
    end
  end
endmodule
`default_nettype wire

// ==== hw/fcbd_pkg.sv ====
// package: constants and types of the fault code blink diagnostics block
`default_nettype none
package fcbd_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int DEB_MS = 10;
  localparam int DEB_CYC = (CLK_HZ / 1000) * DEB_MS;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int SEL_MS = 2000;
  localparam int CLUTCH_MS = 5000;
  localparam logic [3:0] TOGGLE_MIN = 4'h5;
  localparam int NCODE = 17;
  localparam int CIDX_W = 5;
  // fault inputs, one bit each, in ascending code order
  localparam int F_SPEED = 5;
  localparam int F_SPEED2 = 6;
  localparam int F_SUBTHR_S = 8;
  localparam int F_TIPOVER = 7;
  localparam int F_O2INACT = 9;
  typedef logic [NCODE-1:0] fcbd_faults_t;
  typedef struct packed {
    logic [3:0] tens;
    logic [3:0] units;
  } fcbd_code_t;
  typedef enum logic [1:0] {FCBD_RIDER, FCBD_LIVE, FCBD_STORED} fcbd_mode_t;
  typedef struct packed {
    logic inject;
    logic ignite;
    logic starter;
  } fcbd_inhibit_t;
endpackage
`default_nettype wire

// ==== hw/fcbd_store.sv ====
// retained fault memory: sticky bits, cleared only by an erase command or by reset (nrst)
`timescale 1ns/1ns
`default_nettype none
module fcbd_store (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire fcbd_pkg::fcbd_faults_t setBits,
  input wire logic erase,
  output fcbd_pkg::fcbd_faults_t stored
);
  fcbd_pkg::fcbd_faults_t next_stored;
  always_comb begin
    next_stored = erase ? '0 : stored;
    next_stored = next_stored | setBits;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stored <= '0;
    end else begin
      stored <= next_stored;
    end
  end
endmodule
`default_nettype wire

// ==== bench/fcbd_diag_props.sv ====
// checker: port properties of the blink diagnostics block
`timescale 1ns/1ns
`default_nettype none
module fcbd_diag_props #(
  parameter int SEL_CYC = 100,
  parameter int LONG_CYC = 8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ignitionOn,
  input wire logic diagGrounded,
  input wire fcbd_pkg::fcbd_faults_t faultIn,
  input wire logic o2Fitted,
  input wire logic seriousFault,
  input wire logic faultLamp,
  input wire fcbd_pkg::fcbd_inhibit_t inhibit,
  input wire fcbd_pkg::fcbd_mode_t mode,
  input wire fcbd_pkg::fcbd_faults_t storedFaults
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic inRider;
  int gndCnt;
  int onCnt;
  assign inRider = mode == fcbd_pkg::FCBD_RIDER;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gndCnt <= 0;
      onCnt <= 0;
    end else begin
      gndCnt <= diagGrounded ? gndCnt + 1 : 0;
      onCnt <= faultLamp ? onCnt + 1 : 0;
    end
  end
  sequence enter_s;
    inRider ##1 !inRider;
  endsequence
  sequence riderFault_s;
    inRider && faultIn[4:0] != 5'h0 ##1 inRider;
  endsequence
  serious_stop_a: assert property (seriousFault |=> inhibit == 3'h7)
    else $error("inhibit missing");
  rider_lamp_a: assert property (riderFault_s |-> faultLamp)
    else $error("lamp dark");
  store_sets_a: assert property (1'b1 |=> (storedFaults[4:0] & $past(faultIn[4:0])) == $past(faultIn[4:0]))
    else $error("fault not stored");
  store_keep_a: assert property (mode != fcbd_pkg::FCBD_STORED |=>
    (storedFaults & $past(storedFaults)) == $past(storedFaults)) else $error("memory lost");
  o2_mask_a: assert property (!o2Fitted && !storedFaults[fcbd_pkg::F_O2INACT] |=>
    !storedFaults[fcbd_pkg::F_O2INACT]) else $error("oxygen code stored");
  speed_pair_a: assert property (faultIn[fcbd_pkg::F_SPEED] |=> storedFaults[fcbd_pkg::F_SPEED2])
    else $error("second speed code missing");
  entry_hold_a: assert property (enter_s |-> gndCnt >= SEL_CYC)
    else $error("display entered early");
  no_skip_a: assert property (mode == fcbd_pkg::FCBD_LIVE |=> mode != fcbd_pkg::FCBD_STORED)
    else $error("live to stored");
  ign_off_a: assert property (!ignitionOn [*4] |-> inRider)
    else $error("mode kept at ignition off");
  release_exit_a: assert property (!diagGrounded [*8] |-> inRider)
    else $error("display kept after release");
  blink_len_a: assert property (!inRider && !$past(inRider, 10) |-> onCnt <= LONG_CYC)
    else $error("blink too long");
endmodule
bind fcbd_diag fcbd_diag_props #(.SEL_CYC(SEL_CYC), .LONG_CYC(LONG_CYC)) fcbd_diag_props_i (
  .sys_clk(sys_clk), .nrst(nrst), .ignitionOn(ignitionOn), .diagGrounded(diagGrounded),
  .faultIn(faultIn), .o2Fitted(o2Fitted), .seriousFault(seriousFault), .faultLamp(faultLamp),
  .inhibit(inhibit), .mode(mode), .storedFaults(storedFaults)
);
`default_nettype wire

// ==== bench/fcbd_tech.sv ====
// technician model: terminal, clutch lever and lamp reading
`timescale 1ns/1ns
`default_nettype none
module fcbd_tech (
  input wire logic sys_clk,
  input wire logic faultLamp,
  output logic diagGrounded,
  output logic clutchPulled
);
  initial begin
    diagGrounded = 1'b0;
    clutchPulled = 1'b0;
  end
  task automatic drive_gnd(input logic v, input int n);
    diagGrounded <= v;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic toggles(input int k);
    repeat (k) begin
      drive_gnd(1'b0, 6);
      drive_gnd(1'b1, 6);
    end
  endtask
  task automatic clutch(input int n);
    clutchPulled <= 1'b1;
    repeat (n) @(posedge sys_clk);
    clutchPulled <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic read_code(output int code);
    int w;
    int off;
    int t;
    int u;
    code = -1;
    w = 0;
    off = 0;
    t = 0;
    u = 0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge sys_clk);
      if (faultLamp === 1'b1) begin
        w++;
        off = 0;
      end else begin
        if (w > 6) t++;
        else if (w > 0) u++;
        w = 0;
        off++;
        if (off > 8 && t + u > 0) begin
          code = t * 10 + u;
          break;
        end
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== bench/tb_fcbd_diag.sv ====
// testbench: modes, blink readout, memory and clearing
`timescale 1ns/1ns
`default_nettype none
module tb_fcbd_diag;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic ignitionOn = 1'b0;
  logic o2Fitted = 1'b0;
  logic seriousFault = 1'b0;
  logic diagGrounded;
  logic clutchPulled;
  logic faultLamp;
  fcbd_pkg::fcbd_faults_t faultIn = 17'h0;
  fcbd_pkg::fcbd_inhibit_t inhibit;
  fcbd_pkg::fcbd_mode_t mode;
  fcbd_pkg::fcbd_faults_t storedFaults;
  int err_count = 0;
  int n_checks = 0;
  always #10 sys_clk = ~sys_clk;
  fcbd_diag #(.LONG_CYC(8), .SHORT_CYC(4), .GAP_CYC(4), .DIGIT_GAP_CYC(6), .CODE_GAP_CYC(10),
    .SEL_CYC(100), .CLUTCH_CYC(200), .DEB_CYC(2)) fcbd_diag_i (
    .sys_clk(sys_clk), .nrst(nrst), .ignitionOn(ignitionOn), .diagGrounded(diagGrounded),
    .clutchPulled(clutchPulled), .faultIn(faultIn), .o2Fitted(o2Fitted), .seriousFault(seriousFault),
    .faultLamp(faultLamp), .inhibit(inhibit), .mode(mode), .storedFaults(storedFaults)
  );
  fcbd_tech fcbd_tech_i (
    .sys_clk(sys_clk), .faultLamp(faultLamp), .diagGrounded(diagGrounded), .clutchPulled(clutchPulled)
  );
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic wait_mode(input fcbd_pkg::fcbd_mode_t m);
    for (int i = 0; i < 50 && mode !== m; i++) @(posedge sys_clk);
    check(mode === m, "mode not reached");
    if (mode !== m) give_verdict();
  endtask
  function automatic int nxt(input int c);
    case (c)
      12: return 21;
      21: return 24;
      24: return 25;
      25: return 12;
      default: return -1;
    endcase
  endfunction
  task automatic read_cycle(input int n);
    int c;
    int p;
    fcbd_tech_i.read_code(p);
    fcbd_tech_i.read_code(p);
    repeat (n) begin
      fcbd_tech_i.read_code(c);
      check(c >= 0 && c == nxt(p), "code sequence");
      if (c < 0) give_verdict();
      p = c;
    end
  endtask
  task automatic t_rider();
    faultIn <= 17'h00232;
    seriousFault <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(faultLamp === 1'b1, "lamp dark");
    check(inhibit === 3'h7, "no inhibit");
    check(storedFaults === 17'h00072, "memory");
    faultIn <= 17'h0;
    seriousFault <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(faultLamp === 1'b0, "lamp lit");
    check(inhibit === 3'h0, "inhibit stuck");
    check(storedFaults === 17'h00072, "memory lost");
  endtask
  task automatic t_live();
    faultIn <= 17'h00032;
    fcbd_tech_i.drive_gnd(1'b1, 130);
    wait_mode(fcbd_pkg::FCBD_LIVE);
    read_cycle(4);
    fcbd_tech_i.toggles(7);
    fcbd_tech_i.drive_gnd(1'b1, 130);
    check(mode !== fcbd_pkg::FCBD_STORED, "skipped to stored");
    fcbd_tech_i.drive_gnd(1'b0, 12);
    check(mode === fcbd_pkg::FCBD_RIDER, "display kept");
  endtask
  task automatic t_stored();
    faultIn <= 17'h0;
    ignitionOn <= 1'b0;
    repeat (5) @(posedge sys_clk);
    ignitionOn <= 1'b1;
    fcbd_tech_i.drive_gnd(1'b1, 6);
    fcbd_tech_i.toggles(7);
    fcbd_tech_i.drive_gnd(1'b1, 130);
    wait_mode(fcbd_pkg::FCBD_STORED);
    check(storedFaults === 17'h00072, "memory lost");
    read_cycle(4);
  endtask
  task automatic t_clear();
    fcbd_tech_i.clutch(220);
    fcbd_tech_i.toggles(7);
    fcbd_tech_i.drive_gnd(1'b1, 220);
    check(storedFaults === 17'h0, "not erased");
    fcbd_tech_i.drive_gnd(1'b0, 12);
    check(faultLamp === 1'b0, "lamp lit");
    o2Fitted <= 1'b1;
    faultIn <= 17'h00200;
    repeat (3) @(posedge sys_clk);
    check(storedFaults === 17'h00200, "oxygen code not stored");
    check(faultLamp === 1'b1, "lamp dark");
    faultIn <= 17'h0;
    o2Fitted <= 1'b0;
    @(posedge sys_clk);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    ignitionOn <= 1'b1;
    @(posedge sys_clk);
    t_rider();
    t_live();
    t_stored();
    t_clear();
    give_verdict();
  end
endmodule
`default_nettype wire
